// *** inc/burst_seq_pkg.sv ***
// Behaviour
// RULE1 - wrapped burst stays inside one group aligned to the group length
// RULE2 - groups of 16, 32, 64 and 128 bytes set both alignment and size
// RULE3 - wrap starts at given word, runs to group end, then from group start
// RULE4 - host never issues a wrapped burst straddling two stacked dies
// RULE5 - hybrid wraps once fully, then goes to first word of next group
// RULE6 - after the wrap a hybrid burst increments linearly until select rises
// RULE7 - host never issues a hybrid burst crossing two stacked dies
// RULE8 - config bit 2: zero hybrid, one legacy wrap; reset value one
// RULE9 - addresses count 16-bit words, a group of N bytes is N/2 words
// RULE10 - burst-type bit one forces linear and ignores the wrap-style bit
// RULE11 - length code 00=128, 01=64, 10=16, 11=32 bytes; reset value 11
// RULE12 - address sequence stops whenever the host raises the select
package burst_seq_pkg;
  localparam int ADDR_W = 32;
  localparam int CA_W = 48;
  localparam int CFG_W = 3;
  localparam int CNT_W = 7;
  localparam int FIFO_DEPTH = 8;
  // command_address layout
  localparam int CA_TYPE_BIT = 45;
  localparam int CA_ROW_HI = 44;
  localparam int CA_ROW_LO = 16;
  localparam int CA_COL_HI = 2;
  // config_reg_zero fields kept by this block
  localparam int CFG_STYLE_BIT = 2;
  localparam int CFG_LEN_HI = 1;
  localparam int CFG_LEN_LO = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h7;
  localparam logic [1:0] LEN_128 = 2'h0;
  localparam logic [1:0] LEN_64 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h2;
  localparam logic [1:0] LEN_32 = 2'h3;
  // group length in words minus one
  localparam logic [CNT_W-1:0] MASK_128 = 7'h3F;
  localparam logic [CNT_W-1:0] MASK_64 = 7'h1F;
  localparam logic [CNT_W-1:0] MASK_32 = 7'h0F;
  localparam logic [CNT_W-1:0] MASK_16 = 7'h07;
  typedef enum logic [1:0] {
    MODE_LINEAR,
    MODE_LEGACY,
    MODE_HYBRID
  } burst_mode_t;
endpackage : burst_seq_pkg

// *** inc/addr_stream_if.sv ***
`timescale 1ns/1ps
interface addr_stream_if #(parameter int W = 32);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, input wr_data, input rd_ready,
                output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
endinterface : addr_stream_if

// *** design/addr_fifo.sv ***
`timescale 1ns/1ps
module addr_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk_i,
  input wire logic wr_nrst_i,
  input wire logic rd_clk_i,
  input wire logic rd_nrst_i,
  addr_stream_if.fifo port_io
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wr_bin_r, wr_bin_nxt, wr_gray_r, wr_gray_nxt;
  logic [AW:0] rd_bin_r, rd_bin_nxt, rd_gray_r, rd_gray_nxt;
  logic [AW:0] rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
  logic full, empty, push, pop;

  // gray pointers cross the domains, so only one bit moves per step
  assign full = (wr_gray_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
  assign empty = (rd_gray_r == wg_s2_r);
  assign push = port_io.wr_valid && !full;
  assign pop = port_io.rd_ready && !empty;
  assign port_io.wr_ready = !full;
  assign port_io.rd_valid = !empty;
  assign port_io.rd_data = mem_r[rd_bin_r[AW-1:0]];

  always_comb begin
    wr_bin_nxt = wr_bin_r + {{AW{1'b0}}, push};
    wr_gray_nxt = wr_bin_nxt ^ (wr_bin_nxt >> 1);
    rd_bin_nxt = rd_bin_r + {{AW{1'b0}}, pop};
    rd_gray_nxt = rd_bin_nxt ^ (rd_bin_nxt >> 1);
  end

  always_ff @(posedge wr_clk_i) begin
    if (push) begin
      mem_r[wr_bin_r[AW-1:0]] <= port_io.wr_data;
    end
  end

  always_ff @(posedge wr_clk_i) begin
    if (!wr_nrst_i) begin
      wr_bin_r <= '0;
      wr_gray_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else begin
      wr_bin_r <= wr_bin_nxt;
      wr_gray_r <= wr_gray_nxt;
      rg_s1_r <= rd_gray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  always_ff @(posedge rd_clk_i) begin
    if (!rd_nrst_i) begin
      rd_bin_r <= '0;
      rd_gray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      rd_bin_r <= rd_bin_nxt;
      rd_gray_r <= rd_gray_nxt;
      wg_s1_r <= wr_gray_r;
      wg_s2_r <= wg_s1_r;
    end
  end
endmodule : addr_fifo

// *** design/wrap_hybrid_burst_sequencer.sv ***
`timescale 1ns/1ps
module wrap_hybrid_burst_sequencer
  import burst_seq_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic link_sel_n_i,
  input wire logic link_ca_valid_i,
  input wire logic [CA_W-1:0] link_ca_i,
  input wire logic link_word_i,
  input wire logic link_cfg_wr_i,
  input wire logic [15:0] link_cfg_data_i,
  output logic link_ready_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_valid_o,
  input wire logic addr_ready_i
);
  localparam logic [ADDR_W-CNT_W-1:0] MASK_PAD = '0;

  addr_stream_if #(.W(ADDR_W)) fq ();

  // reset brought into the link domain; needs a few link edges to release
  logic rs1_r, rs2_r;
  always_ff @(posedge link_clk_i) begin
    rs1_r <= nrst_i;
    rs2_r <= rs1_r;
  end
  wire link_rst_n = rs2_r;

  function automatic logic [CNT_W-1:0] len_mask(input logic [1:0] code);
    case (code)
      LEN_128: len_mask = MASK_128;
      LEN_64: len_mask = MASK_64;
      LEN_16: len_mask = MASK_16;
      LEN_32: len_mask = MASK_32;
      default: len_mask = MASK_32;
    endcase
  endfunction : len_mask

  logic [CFG_W-1:0] cfg_r, cfg_nxt;
  burst_mode_t mode_r, mode_nxt;
  logic active_r, active_nxt;
  logic done_r, done_nxt;
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [ADDR_W-1:0] cur_r, cur_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] mask_r, mask_nxt;
  logic [ADDR_W-1:0] ca_addr, mask32, new_mask32, wrap_addr;
  logic [CNT_W-1:0] cfg_mask;
  logic push, wrapping, ca_take;

  assign ca_addr = {link_ca_i[CA_ROW_HI:CA_ROW_LO], link_ca_i[CA_COL_HI:0]};
  assign cfg_mask = len_mask(cfg_r[CFG_LEN_HI:CFG_LEN_LO]); // RULE11
  assign mask32 = {MASK_PAD, mask_r};
  assign new_mask32 = {MASK_PAD, cfg_mask};
  assign ca_take = link_ca_valid_i && !link_sel_n_i;
  // each data word consumes one word address; a command cycle carries no word
  assign push = active_r && link_word_i && !link_sel_n_i && !ca_take &&
                fq.wr_ready; // RULE12 RULE9
  assign wrapping = (mode_r != MODE_LINEAR) && !done_r;
  assign wrap_addr = base_r | ((cur_r + 32'h1) & mask32); // RULE1
  assign fq.wr_valid = push;
  assign fq.wr_data = cur_r;
  // host is stalled while the crossing buffer is full
  assign link_ready_o = fq.wr_ready;

  always_comb begin
    cfg_nxt = cfg_r;
    mode_nxt = mode_r;
    active_nxt = active_r;
    done_nxt = done_r;
    base_nxt = base_r;
    cur_nxt = cur_r;
    cnt_nxt = cnt_r;
    mask_nxt = mask_r;
    if (link_cfg_wr_i) begin
      cfg_nxt = link_cfg_data_i[CFG_W-1:0];
    end
    if (link_sel_n_i) begin
      active_nxt = 1'b0; // RULE12
    end else if (ca_take) begin
      active_nxt = 1'b1;
      mask_nxt = cfg_mask; // RULE2
      base_nxt = ca_addr & ~new_mask32; // RULE1
      cur_nxt = ca_addr; // RULE3
      cnt_nxt = '0;
      done_nxt = 1'b0;
      if (link_ca_i[CA_TYPE_BIT]) begin
        mode_nxt = MODE_LINEAR; // RULE10
      end else if (cfg_r[CFG_STYLE_BIT]) begin
        mode_nxt = MODE_LEGACY; // RULE8
      end else begin
        mode_nxt = MODE_HYBRID; // RULE8
      end
    end else if (push) begin
      if (!wrapping) begin
        cur_nxt = cur_r + 32'h1; // RULE6
      end else if (cnt_r == mask_r) begin
        cnt_nxt = '0;
        if (mode_r == MODE_HYBRID) begin
          done_nxt = 1'b1;
          cur_nxt = base_r + mask32 + 32'h1; // RULE5
        end else begin
          cur_nxt = wrap_addr; // RULE3
        end
      end else begin
        cnt_nxt = cnt_r + 7'h01;
        cur_nxt = wrap_addr; // RULE3
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n) begin
      cfg_r <= CFG_RESET; // RULE8 RULE11
      mode_r <= MODE_LINEAR;
      active_r <= 1'b0;
      done_r <= 1'b0;
      base_r <= '0;
      cur_r <= '0;
      cnt_r <= '0;
      mask_r <= MASK_32;
    end else begin
      cfg_r <= cfg_nxt;
      mode_r <= mode_nxt;
      active_r <= active_nxt;
      done_r <= done_nxt;
      base_r <= base_nxt;
      cur_r <= cur_nxt;
      cnt_r <= cnt_nxt;
      mask_r <= mask_nxt;
    end
  end

  addr_fifo #(.W(ADDR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clk_i(link_clk_i),
    .wr_nrst_i(link_rst_n),
    .rd_clk_i(clock_i),
    .rd_nrst_i(nrst_i),
    .port_io(fq)
  );

  // output stage in the system clock domain
  logic [ADDR_W-1:0] out_addr_r, out_addr_nxt;
  logic out_valid_r, out_valid_nxt;
  logic pop;

  assign fq.rd_ready = !out_valid_r || addr_ready_i;
  assign pop = fq.rd_valid && fq.rd_ready;
  assign addr_o = out_addr_r;
  assign addr_valid_o = out_valid_r;

  always_comb begin
    out_addr_nxt = out_addr_r;
    out_valid_nxt = out_valid_r;
    if (pop) begin
      out_addr_nxt = fq.rd_data;
      out_valid_nxt = 1'b1;
    end else if (addr_ready_i) begin
      out_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      out_addr_r <= '0;
      out_valid_r <= 1'b0;
    end else begin
      out_addr_r <= out_addr_nxt;
      out_valid_r <= out_valid_nxt;
    end
  end

  // checks on the link side
  sequence ca_wrap_s;
    ca_take && !link_ca_i[CA_TYPE_BIT];
  endsequence

  sequence last_wrap_word_s;
    push && wrapping && (cnt_r == mask_r);
  endsequence

  chk_group_confine: assert property ( // RULE1
    @(posedge link_clk_i) disable iff (!link_rst_n)
    push && wrapping |-> ((cur_r & ~mask32) == base_r))
    else $error("wrapped access left its group");

  chk_group_sizes: assert property ( // RULE2
    @(posedge link_clk_i) disable iff (!link_rst_n)
    active_r |-> (mask_r == MASK_16 || mask_r == MASK_32 ||
                  mask_r == MASK_64 || mask_r == MASK_128))
    else $error("group size not one of the four lengths");

  chk_start_word: assert property ( // RULE3
    @(posedge link_clk_i) disable iff (!link_rst_n)
    ca_take ##1 (!link_sel_n_i && !ca_take && link_word_i && fq.wr_ready)
      |-> (fq.wr_data == $past(ca_addr, 1)))
    else $error("burst did not start at selected word");

  chk_wrap_return: assert property ( // RULE3
    @(posedge link_clk_i) disable iff (!link_rst_n)
    last_wrap_word_s ##0 ((mode_r == MODE_LEGACY) && !link_sel_n_i && !ca_take)
      |=> (cur_r == ($past(base_r) | (($past(cur_r) + 32'h1) & $past(mask32)))))
    else $error("legacy wrap did not return inside group");

  chk_hybrid_next: assert property ( // RULE5
    @(posedge link_clk_i) disable iff (!link_rst_n)
    last_wrap_word_s ##0 ((mode_r == MODE_HYBRID) && !link_sel_n_i && !ca_take)
      |=> done_r && (cur_r == $past(base_r) + $past(mask32) + 32'h1))
    else $error("hybrid burst did not move to next group");

  chk_linear_step: assert property ( // RULE6
    @(posedge link_clk_i) disable iff (!link_rst_n)
    push && !wrapping && !ca_take |=> (cur_r == $past(cur_r) + 32'h1) && !wrapping)
    else $error("linear phase did not increment by one word");

  chk_style_reset: assert property ( // RULE8
    @(posedge link_clk_i) disable iff (!link_rst_n)
    $rose(link_rst_n) |-> cfg_r[CFG_STYLE_BIT] && (cfg_r[CFG_LEN_HI:CFG_LEN_LO] == LEN_32))
    else $error("config reset value wrong");

  chk_style_select: assert property ( // RULE8
    @(posedge link_clk_i) disable iff (!link_rst_n)
    ca_wrap_s |=> (mode_r == ($past(cfg_r[CFG_STYLE_BIT]) ? MODE_LEGACY : MODE_HYBRID)))
    else $error("wrap style not taken from config bit");

  chk_word_span: assert property ( // RULE9
    @(posedge link_clk_i) disable iff (!link_rst_n)
    ca_take |=> (cnt_r == '0) && ((mask_r + 7'h01) ==
      (($past(cfg_r[CFG_LEN_HI:CFG_LEN_LO]) == LEN_128) ? 7'h40 :
       ($past(cfg_r[CFG_LEN_HI:CFG_LEN_LO]) == LEN_64) ? 7'h20 :
       ($past(cfg_r[CFG_LEN_HI:CFG_LEN_LO]) == LEN_16) ? 7'h08 : 7'h10)))
    else $error("group word span wrong");

  chk_type_linear: assert property ( // RULE10
    @(posedge link_clk_i) disable iff (!link_rst_n)
    ca_take && link_ca_i[CA_TYPE_BIT] |=> (mode_r == MODE_LINEAR))
    else $error("burst-type one did not force linear");

  chk_len_decode: assert property ( // RULE11
    @(posedge link_clk_i) disable iff (!link_rst_n)
    (cfg_r[CFG_LEN_HI:CFG_LEN_LO] == LEN_16) |-> (cfg_mask == 7'h07))
    else $error("length code 10 not 16 bytes");

  chk_stop_select: assert property ( // RULE12
    @(posedge link_clk_i) disable iff (!link_rst_n)
    link_sel_n_i |-> !fq.wr_valid ##1 !active_r)
    else $error("addresses issued with select high");
endmodule : wrap_hybrid_burst_sequencer

// *** bench/host_link_model.sv ***
`timescale 1ns/1ps
module host_link_model (
  output logic link_clk_o,
  output logic sel_n_o,
  output logic ca_valid_o,
  output logic [47:0] ca_o,
  output logic word_o,
  output logic cfg_wr_o,
  output logic [15:0] cfg_data_o,
  input wire logic ready_i
);
  logic ph = 1'b0;
  logic run = 1'b1;
  always #16 ph = ~ph;
  // clock stands still between frames, so gate it while the phase is low
  assign link_clk_o = ph & run;
  initial begin
    sel_n_o = 1'b1;
    ca_valid_o = 1'b0;
    ca_o = 48'h0;
    word_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_data_o = 16'h0;
  end
  task go(input logic on);
    @(negedge ph);
    run = on;
  endtask : go
  task cfg_write(input logic [15:0] d);
    go(1'b1);
    @(posedge link_clk_o);
    #1 cfg_data_o = d;
    cfg_wr_o = 1'b1;
    @(posedge link_clk_o);
    #1 cfg_wr_o = 1'b0;
    cfg_data_o = ~d;
    go(1'b0);
  endtask : cfg_write
  task frame(input logic [47:0] ca, input int n, input bit junk);
    int k;
    logic r;
    go(1'b1);
    @(posedge link_clk_o);
    #1 sel_n_o = 1'b0;
    ca_valid_o = 1'b1;
    ca_o = ca;
    @(posedge link_clk_o);
    #1 ca_valid_o = 1'b0;
    ca_o = ~ca;
    word_o = 1'b1;
    k = 0;
    // ready is sampled mid-cycle, where no flop of either side moves
    while (k < n) begin
      @(negedge link_clk_o);
      r = ready_i;
      @(posedge link_clk_o);
      if (r === 1'b1) k++;
    end
    #1 sel_n_o = 1'b1;
    word_o = junk;
    repeat (3) @(posedge link_clk_o);
    #1 word_o = 1'b0;
    go(1'b0);
  endtask : frame
endmodule : host_link_model

// *** bench/wrap_hybrid_burst_sequencer_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end
module wrap_hybrid_burst_sequencer_test;
  import burst_seq_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic addr_ready_i = 1'b1;
  logic link_clk, sel_n, ca_valid, word, cfg_wr, link_ready, addr_valid;
  logic [CA_W-1:0] ca;
  logic [15:0] cfg_data;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] got[$];
  logic seen_full = 1'b0;
  int fail_count = 0;
  int compares = 0;
  always #2 clock_i = ~clock_i;
  host_link_model host (.link_clk_o(link_clk), .sel_n_o(sel_n), .ca_valid_o(ca_valid),
    .ca_o(ca), .word_o(word), .cfg_wr_o(cfg_wr), .cfg_data_o(cfg_data), .ready_i(link_ready));
  wrap_hybrid_burst_sequencer uut (.clock_i(clock_i), .nrst_i(nrst_i), .link_clk_i(link_clk),
    .link_sel_n_i(sel_n), .link_ca_valid_i(ca_valid), .link_ca_i(ca), .link_word_i(word),
    .link_cfg_wr_i(cfg_wr), .link_cfg_data_i(cfg_data), .link_ready_o(link_ready),
    .addr_o(addr), .addr_valid_o(addr_valid), .addr_ready_i(addr_ready_i));
  always @(posedge clock_i) if (addr_valid === 1'b1 && addr_ready_i) got.push_back(addr);
  always @(negedge link_clk) if (link_ready === 1'b0) seen_full = 1'b1;
  // mode 0 linear, 1 legacy wrap, 2 hybrid; m is group words minus one
  function automatic logic [31:0] exp_addr(logic [31:0] s, int mode, logic [31:0] m, int i);
    if (mode == 0) return s + i;
    if (mode == 2 && i > m) return (s & ~m) + i;
    return (s & ~m) | ((s + i) & m);
  endfunction : exp_addr
  task run(input bit ty, input logic [31:0] s, input int mode, input logic [31:0] m,
           input int n, input bit junk);
    logic [CA_W-1:0] c;
    int t;
    c = '0;
    c[CA_TYPE_BIT] = ty;
    c[CA_ROW_HI:CA_ROW_LO] = s[31:3];
    c[CA_COL_HI:0] = s[2:0];
    got.delete();
    host.frame(c, n, junk);
    t = 0;
    while (got.size() < n && t < 400) begin
      @(posedge clock_i);
      t++;
    end
    // late extras would show up within the crossing delay
    repeat (20) @(posedge clock_i);
    `CHK(got.size(), n)
    for (int i = 0; i < n; i++) `CHK(got[i], exp_addr(s, mode, m, i))
  endtask : run
  task t_default;
    run(1'b0, 32'h1234_560A, 1, 32'h0F, 20, 1'b0);
    $display("test default done");
  endtask : t_default
  task t_modes;
    logic [31:0] m;
    for (int st = 0; st < 2; st++) begin
      for (int cd = 0; cd < 4; cd++) begin
        m = (cd == 0) ? 32'h3F : (cd == 1) ? 32'h1F : (cd == 2) ? 32'h07 : 32'h0F;
        host.cfg_write({13'h0, st[0], cd[1:0]});
        run(1'b0, 32'h0000_402E, st ? 1 : 2, m, m + 6, 1'b0);
      end
    end
    $display("test modes done");
  endtask : t_modes
  task t_linear;
    for (int st = 0; st < 2; st++) begin
      host.cfg_write({13'h0, st[0], 2'h2});
      run(1'b1, 32'h0000_0003, 0, 32'h0, 22, 1'b0);
    end
    $display("test linear done");
  endtask : t_linear
  task t_abort;
    host.cfg_write(16'h0002);
    run(1'b0, 32'h0000_000C, 2, 32'h07, 3, 1'b1);
    $display("test abort done");
  endtask : t_abort
  task t_full;
    @(posedge clock_i);
    #1 addr_ready_i = 1'b0;
    fork
      run(1'b0, 32'h0000_0102, 2, 32'h07, 20, 1'b0);
      begin
        #1500 @(posedge clock_i);
        #1 addr_ready_i = 1'b1;
      end
    join
    `CHK(seen_full, 1'b1)
    $display("test full done");
  endtask : t_full
  task summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    // long enough for the asserted reset to pass the link-side synchroniser
    repeat (40) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    repeat (4) @(posedge link_clk);
    host.go(1'b0);
    t_default;
    t_modes;
    t_linear;
    t_abort;
    t_full;
    summarize;
  end
  initial begin
    #300000;
    fail_count++;
    summarize;
  end
endmodule : wrap_hybrid_burst_sequencer_test
